// file: hdl/dpll_centre_freq_lock_detect.sv
// centre frequency registers, frequency offset status, oscillator and lock detector of the loop
`timescale 1ns/10ps
`include "dpll_cfg.svh"
// What this block does
// - centre number is low register 15:0 plus high register 9:0 on top.
// - output centre frequency is centre number over 2^26 times master clock.
// - offset register bits 14:0 show present deviation, two's complement.
// - lock threshold bounds absolute phase counted as within lock.
// - locked after phase stays within threshold for the programmed duration.
// - unlocked after phase stays above threshold for duration over 256.
// - lock duration counts unsigned steps of 4 ms.
module dpll_centre_freq_lock_detect #(
  parameter int LOCK_TICK_CYC = `LOCK_TICK_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 hostCs,
  input  wire logic                 hostWr,
  input  wire logic                 hostRd,
  input  wire logic [15:0]          hostAddr,
  input  wire dpll_pkg::word_t      hostWdata,
  output dpll_pkg::word_t           hostRdata,
  input  wire logic [14:0]          loopFreqOffset,
  input  wire logic [16:0]          phaseDetOut,
  output dpll_pkg::centre_t         centreNumber,
  output logic                      ncoOut,
  output logic                      lockIndication
);
  import dpll_pkg::*;

  word_t       cfLowQ, cfLowD;
  logic [9:0]  cfHighQ, cfHighD;
  word_t       thresholdQ, thresholdD;
  word_t       durationQ, durationD;
  word_t       rdataQ, rdataD;
  centre_t     accQ, accD;
  centre_t     increment;
  logic [16:0] absPhase;
  logic        withinLimit;
  logic        wrEn, rdEn;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    hit = addr == target;
  endfunction : hit

  // register file
  always_comb begin
    wrEn       = hostCs && hostWr;
    rdEn       = hostCs && hostRd;
    cfLowD     = cfLowQ;
    cfHighD    = cfHighQ;
    thresholdD = thresholdQ;
    durationD  = durationQ;
    if (wrEn) begin
      if (hit(hostAddr, `ADDR_CF_LOW)) begin
        cfLowD = hostWdata;
      end
      if (hit(hostAddr, `ADDR_CF_HIGH)) begin
        cfHighD = hostWdata[`CF_HIGH_MSB:0];        // reserved upper bits not stored
      end
      if (hit(hostAddr, `ADDR_LOCK_THRESHOLD)) begin
        thresholdD = hostWdata;
      end
      if (hit(hostAddr, `ADDR_LOCK_DURATION)) begin
        durationD = hostWdata;
      end
    end
    rdataD = rdataQ;
    if (rdEn) begin
      if (hit(hostAddr, `ADDR_CF_LOW)) begin
        rdataD = cfLowQ;
      end else if (hit(hostAddr, `ADDR_CF_HIGH)) begin
        rdataD = {6'h00, cfHighQ};
      end else if (hit(hostAddr, `ADDR_FREQ_OFFSET)) begin
        rdataD = {1'b0, loopFreqOffset};
      end else if (hit(hostAddr, `ADDR_LOCK_THRESHOLD)) begin
        rdataD = thresholdQ;
      end else if (hit(hostAddr, `ADDR_LOCK_DURATION)) begin
        rdataD = durationQ;
      end else begin
        rdataD = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfLowQ     <= `RST_CF_LOW;
      cfHighQ    <= 10'(`RST_CF_HIGH);
      thresholdQ <= `RST_LOCK_THRESHOLD;
      durationQ  <= `RST_LOCK_DURATION;
      rdataQ     <= 16'h0000;
    end else begin
      cfLowQ     <= cfLowD;
      cfHighQ    <= cfHighD;
      thresholdQ <= thresholdD;
      durationQ  <= durationD;
      rdataQ     <= rdataD;
    end
  end

  assign hostRdata    = rdataQ;
  assign centreNumber = {cfHighQ, cfLowQ};

  // phase accumulator wraps at 2^26, so its top bit runs at increment / 2^26 of clk_sys
  always_comb begin
    increment = centreNumber + {{11{loopFreqOffset[14]}}, loopFreqOffset};
    accD      = accQ + increment;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      accQ <= 26'h0000000;
    end else begin
      accQ <= accD;
    end
  end

  assign ncoOut = accQ[25];

  // most negative phase gives magnitude 2^16, always above any threshold
  always_comb begin
    absPhase    = phaseDetOut[16] ? 17'(-phaseDetOut) : phaseDetOut;
    withinLimit = absPhase <= {1'b0, thresholdQ};
  end

  lock_run_timer #(
    .TICK_CYC (LOCK_TICK_CYC)
  ) u_lock_run_timer (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .withinLimit (withinLimit),
    .duration    (durationQ),
    .locked      (lockIndication)
  );

  property p_cf_low_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostCs && hostWr && hostAddr == `ADDR_CF_LOW)
        |=> centreNumber[15:0] == $past(hostWdata) && centreNumber[25:16] == $past(cfHighQ);
  endproperty
  a_cf_low_write: assert property (p_cf_low_write) else $error("low centre write lost");

  property p_cf_high_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostCs && hostWr && hostAddr == `ADDR_CF_HIGH)
        |=> centreNumber[25:16] == $past(hostWdata[9:0]) && centreNumber[15:0] == $past(cfLowQ);
  endproperty
  a_cf_high_write: assert property (p_cf_high_write) else $error("high centre write lost");

  property p_nco_step;
    @(posedge clk_sys) disable iff (!rst_n)
      // first edge after release still shows the reset value of the accumulator
      $past(rst_n) |-> accQ == 26'($past(accQ) + $past(centreNumber)
                                   + {{11{$past(loopFreqOffset[14])}}, $past(loopFreqOffset)});
  endproperty
  a_nco_step: assert property (p_nco_step) else $error("oscillator step wrong");

  property p_offset_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostCs && hostRd && hostAddr == `ADDR_FREQ_OFFSET) |=> hostRdata[14:0] == $past(loopFreqOffset);
  endproperty
  a_offset_read: assert property (p_offset_read) else $error("offset read wrong");

  property p_offset_top_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostCs && hostRd && hostAddr == `ADDR_FREQ_OFFSET) |=> !hostRdata[15];
  endproperty
  a_offset_top_zero: assert property (p_offset_top_zero) else $error("offset bit 15 set");

  // reserved high bits must never leak back to the host
  property p_high_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (hostCs && hostRd && hostAddr == `ADDR_CF_HIGH) |=> hostRdata == {6'h00, $past(centreNumber[25:16])};
  endproperty
  a_high_read: assert property (p_high_read) else $error("high centre read wrong");

  property p_threshold_bound;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(lockIndication) |-> $past(absPhase) <= {1'b0, $past(thresholdQ)};
  endproperty
  a_threshold_bound: assert property (p_threshold_bound) else $error("lock with phase above threshold");

  c_offset_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    hostCs && hostRd && hostAddr == `ADDR_FREQ_OFFSET && loopFreqOffset[14]);
  c_cf_trim: cover property (@(posedge clk_sys) disable iff (!rst_n)
    hostCs && hostWr && hostAddr == `ADDR_CF_LOW);
  c_nco_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(ncoOut));
endmodule : dpll_centre_freq_lock_detect

// file: hdl/dpll_cfg.svh
// register map, reset values and timing counts of the centre frequency / lock detect block
`ifndef DPLL_CFG_SVH
`define DPLL_CFG_SVH

`define ADDR_CF_LOW          16'h0042
`define ADDR_CF_HIGH         16'h0043
`define ADDR_FREQ_OFFSET     16'h0045
`define ADDR_LOCK_THRESHOLD  16'h0047
`define ADDR_LOCK_DURATION   16'h0048

`define RST_CF_LOW           16'h16b1
`define RST_CF_HIGH          16'h029f
`define RST_LOCK_THRESHOLD   16'h0000
`define RST_LOCK_DURATION    16'h0000

`define CF_HIGH_MSB          9
`define FREQ_OFFSET_MSB      14
`define CENTRE_WIDTH         26

`define CLK_PERIOD_NS        8
`define LOCK_STEP_NS         4000000
`define UNLOCK_DIVISOR       256
`define UNLOCK_SHIFT         8
// one tick is a lock step divided by the unlock divisor; a step length rounds down
`define LOCK_TICK_CYC        ((`LOCK_STEP_NS / `UNLOCK_DIVISOR) / `CLK_PERIOD_NS)

`endif

// file: hdl/dpll_pkg.sv
// types shared by the centre frequency / lock detect block
package dpll_pkg;
  typedef logic [25:0] centre_t;
  typedef logic [15:0] word_t;
  typedef enum logic {LOOP_UNLOCKED, LOOP_LOCKED} lock_state_e;
endpackage : dpll_pkg

// file: hdl/lock_run_timer.sv
// lock detector: measures uninterrupted runs inside or outside the phase threshold
`timescale 1ns/10ps
`include "dpll_cfg.svh"
module lock_run_timer #(
  parameter int TICK_CYC = `LOCK_TICK_CYC
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         withinLimit,
  input  wire dpll_pkg::word_t duration,
  output logic              locked
);
  import dpll_pkg::*;

  logic [15:0] divQ, divD;
  logic [23:0] runQ, runD;
  logic        withinPrevQ, crossing, tick;
  lock_state_e stateQ, stateD;

  always_comb begin
    crossing = withinLimit != withinPrevQ;
    tick     = !crossing && (divQ == 16'(TICK_CYC - 1));
    divD     = (crossing || tick) ? 16'h0000 : divQ + 16'h0001;
    runD     = runQ;
    if (crossing) begin
      runD = 24'h000000;
    end else if (tick && runQ != 24'hffffff) begin
      runD = runQ + 24'h000001;
    end
    stateD = stateQ;
    case (stateQ)
      LOOP_UNLOCKED: begin
        if (!crossing && withinLimit && runQ >= {duration, 8'h00}) begin
          stateD = LOOP_LOCKED;
        end
      end
      LOOP_LOCKED: begin
        if (!crossing && !withinLimit && runQ >= {8'h00, duration}) begin
          stateD = LOOP_UNLOCKED;
        end
      end
      default: stateD = LOOP_UNLOCKED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divQ        <= 16'h0000;
      runQ        <= 24'h000000;
      withinPrevQ <= 1'b0;
      stateQ      <= LOOP_UNLOCKED;
    end else begin
      divQ        <= divD;
      runQ        <= runD;
      withinPrevQ <= withinLimit;
      stateQ      <= stateD;
    end
  end

  assign locked = stateQ == LOOP_LOCKED;

  property p_lock_after_run;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(locked) |-> $past(withinLimit) && $past(runQ) >= {$past(duration), 8'h00};
  endproperty
  a_lock_after_run: assert property (p_lock_after_run) else $error("lock declared before full run");

  property p_unlock_after_run;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(locked) |-> !$past(withinLimit) && $past(runQ) >= {8'h00, $past(duration)};
  endproperty
  a_unlock_after_run: assert property (p_unlock_after_run) else $error("unlock before short run");

  property p_restart_on_cross;
    @(posedge clk_sys) disable iff (!rst_n)
      (withinLimit != withinPrevQ) |=> runQ == 24'h000000 && divQ == 16'h0000;
  endproperty
  a_restart_on_cross: assert property (p_restart_on_cross) else $error("run not restarted");

  property p_tick_advances_run;
    @(posedge clk_sys) disable iff (!rst_n)
      (withinLimit == withinPrevQ && divQ == 16'(TICK_CYC - 1) && runQ != 24'hffffff)
        |=> runQ == $past(runQ) + 24'h000001 && divQ == 16'h0000;
  endproperty
  a_tick_advances_run: assert property (p_tick_advances_run) else $error("tick period wrong");

  c_locks: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(locked));
  c_unlocks: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(locked));
endmodule : lock_run_timer

// file: test/testbench.sv
// self-checking bench of the centre frequency / lock detect block
`timescale 1ns/10ps
`include "dpll_cfg.svh"
module testbench;
  import dpll_pkg::*;
  // short tick keeps the 256-tick lock run near a thousand cycles
  localparam int TICK = 4;
  logic        clk_sys        = 1'b0;
  logic        rst_n          = 1'b0;
  logic        hostCs         = 1'b0;
  logic        hostWr         = 1'b0;
  logic        hostRd         = 1'b0;
  logic [15:0] hostAddr       = 16'h0000;
  word_t       hostWdata      = 16'h0000;
  word_t       hostRdata;
  logic [14:0] loopFreqOffset = 15'h0000;
  logic [16:0] phaseDetOut    = 17'h00000;
  centre_t     centreNumber;
  logic        ncoOut;
  logic        lockIndication;
  logic        ncoPrev        = 1'b0;
  int          error_cnt      = 0;
  int          checked        = 0;
  int          rises          = 0;
  int          r0;
  word_t       rdVal;

  always #4 clk_sys = ~clk_sys;

  dpll_centre_freq_lock_detect #(.LOCK_TICK_CYC(TICK)) u_dpll_centre_freq_lock_detect (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .hostCs         (hostCs),
    .hostWr         (hostWr),
    .hostRd         (hostRd),
    .hostAddr       (hostAddr),
    .hostWdata      (hostWdata),
    .hostRdata      (hostRdata),
    .loopFreqOffset (loopFreqOffset),
    .phaseDetOut    (phaseDetOut),
    .centreNumber   (centreNumber),
    .ncoOut         (ncoOut),
    .lockIndication (lockIndication)
  );

  // rising edges of the oscillator output, sampled on the clock
  always @(posedge clk_sys) begin
    ncoPrev <= ncoOut;
    if (ncoOut === 1'b1 && ncoPrev === 1'b0) begin
      rises <= rises + 1;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [15:0] addr, input word_t data);
    @(posedge clk_sys);
    hostCs    <= 1'b1;
    hostWr    <= 1'b1;
    hostAddr  <= addr;
    hostWdata <= data;
    @(posedge clk_sys);
    hostCs <= 1'b0;
    hostWr <= 1'b0;
  endtask : wr

  task rd(input logic [15:0] addr, output word_t data);
    @(posedge clk_sys);
    hostCs   <= 1'b1;
    hostRd   <= 1'b1;
    hostAddr <= addr;
    @(posedge clk_sys);
    hostCs <= 1'b0;
    hostRd <= 1'b0;
    #1;
    data = hostRdata;
  endtask : rd

  task cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cycles

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    cycles(1);
    chk(centreNumber, 32'h029f16b1);
    rd(`ADDR_CF_LOW, rdVal);
    chk(rdVal, 16'h16b1);
    rd(`ADDR_CF_HIGH, rdVal);
    chk(rdVal, 16'h029f);
    rd(`ADDR_LOCK_THRESHOLD, rdVal);
    chk(rdVal, 16'h0000);
    rd(`ADDR_LOCK_DURATION, rdVal);
    chk(rdVal, 16'h0000);
    // zero duration with phase inside a zero threshold locks at once
    chk(lockIndication, 1'b1);
    wr(`ADDR_CF_LOW, 16'h1234);
    wr(`ADDR_CF_HIGH, 16'h0155);
    #1;
    chk(centreNumber, 32'h01551234);
    rd(`ADDR_CF_HIGH, rdVal);
    chk(rdVal, 16'h0155);
    // trim for a master clock running fast by 20 ppm
    wr(`ADDR_CF_LOW, 16'h1341);
    wr(`ADDR_CF_HIGH, 16'h029f);
    #1;
    chk(centreNumber, 32'h029f1341);
    // a negative and a positive deviation; bit 15 must stay clear for both
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      loopFreqOffset <= (i == 0) ? 15'h4abc : 15'h01b8;
      rd(`ADDR_FREQ_OFFSET, rdVal);
      chk(rdVal, {1'b0, loopFreqOffset});
    end
    rd(16'h0044, rdVal);
    chk(rdVal, 16'h0000);
    @(posedge clk_sys);
    loopFreqOffset <= 15'h0000;
    // centre of 2^22 gives exactly one output period every 16 clocks
    wr(`ADDR_CF_LOW, 16'h0000);
    wr(`ADDR_CF_HIGH, 16'h0040);
    cycles(20);
    r0 = rises;
    cycles(1600);
    chk(rises - r0, 100);
    // phase far outside first, so the lock run below starts unlocked
    @(posedge clk_sys);
    phaseDetOut <= 17'h00100;
    cycles(4);
    chk(lockIndication, 1'b0);
    wr(`ADDR_LOCK_THRESHOLD, 16'h0010); // 121.6 ns jitter over 15.2, doubled
    wr(`ADDR_LOCK_DURATION, 16'h0001);
    @(posedge clk_sys);
    phaseDetOut <= 17'h00010;
    cycles(600);
    // short excursion must throw away the 600 cycles already counted
    @(posedge clk_sys);
    phaseDetOut <= 17'h00011;
    @(posedge clk_sys);
    @(posedge clk_sys);
    phaseDetOut <= 17'h00010;
    cycles(1000);
    chk(lockIndication, 1'b0);
    for (int i = 0; i < 64 && lockIndication !== 1'b1; i++) begin
      cycles(1);
    end
    chk(lockIndication, 1'b1);
    @(posedge clk_sys);
    phaseDetOut <= 17'h1ffef;
    cycles(2);
    chk(lockIndication, 1'b1);
    cycles(8);
    chk(lockIndication, 1'b0);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
endmodule : testbench
